// >>> hrs_pkg.sv
// Shared constants for the HDLC receive status block
package hrs_pkg;

    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS_A   = 8'h03;
    localparam logic [7:0] IDX_STATUS_B   = 8'ha3;
    localparam logic [7:0] IDX_LINK_MASK  = 8'h10;
    localparam logic [7:0] IDX_IRQ_MASK_A = 8'h11;
    localparam logic [7:0] IDX_IRQ_MASK_B = 8'h12;
    localparam logic [7:0] IDX_TX_EVENTS  = 8'h13;

    // ---------------------------------------------------------------
    // Field positions of the receive status byte
    // ---------------------------------------------------------------
    localparam int unsigned BIT_ABORT = 7;
    localparam int unsigned BIT_FCS   = 6;
    localparam int unsigned BIT_OVR   = 5;
    localparam int unsigned BIT_MSG   = 4;
    localparam int unsigned BIT_EMPTY = 3;
    localparam int unsigned BIT_GOOD  = 2;
    localparam int unsigned BIT_CLOSE = 1;
    localparam int unsigned BIT_OPEN  = 0;

    // Field positions of the transmit event mask and status
    localparam int unsigned BIT_TX_HALF = 2;
    localparam int unsigned BIT_TX_ROOM = 1;
    localparam int unsigned BIT_TX_DONE = 0;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] STATUS_RST    = 8'h08;
    localparam logic [7:0] IRQ_MASK_RST  = 8'h00;
    localparam logic [2:0] LINK_MASK_RST = 3'h0;
    localparam logic [2:0] TX_EVENTS_RST = 3'h0;

    // ---------------------------------------------------------------
    // Abort detection: ones already seen before the seventh one
    // ---------------------------------------------------------------
    localparam logic [2:0] ABORT_RUN = 3'h6;
    localparam logic [2:0] RUN_MAX   = 3'h7;

    // Bus data phase tracking
    typedef enum logic [0:0] {
        HRS_PH_IDLE  = 1'b0,
        HRS_PH_WRITE = 1'b1
    } hrs_phase_t;

endpackage : hrs_pkg

// >>> hrs_framer_status.sv
// Receive status byte of one framer: sticky events and head-byte tags
module hrs_framer_status
    import hrs_pkg::*;
(
    input  wire logic       hclk,               // Device clock
    input  wire logic       hresetn,            // Async reset, active low
    input  wire logic       rx_bit,             // Data-link bit
    input  wire logic       rx_bit_en,          // Data-link bit strobe
    input  wire logic       fcs_bad,            // Packet check failed
    input  wire logic       rx_push,            // Receiver pushes a byte
    input  wire logic       rx_fifo_full,       // Receive FIFO full
    input  wire logic       msg_checked,        // Packet complete, checked
    input  wire logic       rx_fifo_empty_now,  // Receive FIFO empty
    input  wire logic       head_open,          // Head byte opens message
    input  wire logic       head_close,         // Head byte ends message
    input  wire logic       head_good,          // Head message was good
    input  wire logic       rd_clr,             // Status read this cycle
    output logic      [7:0] rx_link_status      // Status byte
);

    typedef struct packed {
        logic [2:0] ones;
        logic [7:0] stat;
    } hrs_fs_state_t;

    hrs_fs_state_t st_ff;
    hrs_fs_state_t nxt_st;
    logic          abort_seen;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        abort_seen = rx_bit_en && rx_bit && (st_ff.ones >= ABORT_RUN);
        // Run of ones saturates so a long idle still counts as abort
        if (rx_bit_en) begin
            if (!rx_bit) begin
                nxt_st.ones = 3'h0;
            end else if (st_ff.ones != RUN_MAX) begin
                nxt_st.ones = st_ff.ones + 3'h1;
            end
        end
        // Sticky bits: a set in the clearing cycle wins
        if (rd_clr) begin
            nxt_st.stat[BIT_ABORT] = 1'b0;
            nxt_st.stat[BIT_FCS]   = 1'b0;
            nxt_st.stat[BIT_OVR]   = 1'b0;
            nxt_st.stat[BIT_MSG]   = 1'b0;
        end
        if (abort_seen) begin
            nxt_st.stat[BIT_ABORT] = 1'b1;
        end
        if (fcs_bad) begin
            nxt_st.stat[BIT_FCS] = 1'b1;
        end
        if (rx_push && rx_fifo_full) begin
            nxt_st.stat[BIT_OVR] = 1'b1;
        end
        if (msg_checked) begin
            nxt_st.stat[BIT_MSG] = 1'b1;
        end
        // Real-time bits follow the FIFO head with one flop of delay
        nxt_st.stat[BIT_EMPTY] = rx_fifo_empty_now;
        nxt_st.stat[BIT_GOOD]  = head_close && head_good;
        nxt_st.stat[BIT_CLOSE] = head_close;
        nxt_st.stat[BIT_OPEN]  = head_open;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{ones: 3'h0, stat: STATUS_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rx_link_status = st_ff.stat;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_abort_run: assert property (
        rx_bit_en && rx_bit && st_ff.ones == ABORT_RUN
        |=> rx_link_status[BIT_ABORT])
        else $error("abort flag missed after seven ones");
    a_fcs_set: assert property (
        fcs_bad |=> rx_link_status[BIT_FCS])
        else $error("fcs error flag missed");
    a_ovr_set: assert property (
        rx_push && rx_fifo_full |=> rx_link_status[BIT_OVR])
        else $error("overrun flag missed");
    a_msg_set: assert property (
        msg_checked |=> rx_link_status[BIT_MSG])
        else $error("message complete flag missed");
    a_empty_live: assert property (
        1'b1 |=> rx_link_status[BIT_EMPTY] == $past(rx_fifo_empty_now))
        else $error("empty bit does not follow fifo");
    a_good_tag: assert property (
        1'b1 |=> rx_link_status[BIT_GOOD]
                 == ($past(head_close) && $past(head_good)))
        else $error("packet ok bit wrong");
    a_close_tag: assert property (
        1'b1 |=> rx_link_status[BIT_CLOSE] == $past(head_close))
        else $error("closing byte bit wrong");
    a_open_tag: assert property (
        1'b1 |=> rx_link_status[BIT_OPEN] == $past(head_open))
        else $error("opening byte bit wrong");
    a_fcs_clear: assert property (
        rd_clr && !fcs_bad |=> !rx_link_status[BIT_FCS])
        else $error("fcs flag not cleared by read");

endmodule : hrs_framer_status

// >>> hrs_status_top.sv
// AHB-Lite register front end for the two framers' receive status
module hrs_status_top
    import hrs_pkg::*;
(
    input  wire logic              hclk,          // Device clock, 25 MHz
    input  wire logic              hresetn,       // Async reset, active low
    // AHB-Lite slave
    input  wire logic              hsel,          // Slave select
    input  wire logic [ADDR_W-1:0] haddr,         // Byte address
    input  wire logic        [1:0] htrans,        // Transfer type
    input  wire logic              hwrite,        // Write when high
    input  wire logic        [2:0] hsize,         // Transfer size
    input  wire logic [DATA_W-1:0] hwdata,        // Write data
    input  wire logic              hready,        // Bus ready
    output logic      [DATA_W-1:0] hrdata,        // Read data
    output logic                   hreadyout,     // Slave ready
    output logic                   hresp,         // Always OKAY
    // Framer A receive side
    input  wire logic              fa_rx_bit,     // Data-link bit
    input  wire logic              fa_rx_bit_en,  // Bit strobe
    input  wire logic              fa_fcs_bad,    // Check failed
    input  wire logic              fa_rx_push,    // Byte push
    input  wire logic              fa_fifo_full,  // FIFO full
    input  wire logic              fa_msg_done,   // Packet checked
    input  wire logic              fa_fifo_empty, // FIFO empty
    input  wire logic              fa_head_open,  // Head opens message
    input  wire logic              fa_head_close, // Head ends message
    input  wire logic              fa_head_good,  // Head message good
    // Framer B receive side
    input  wire logic              fb_rx_bit,     // Data-link bit
    input  wire logic              fb_rx_bit_en,  // Bit strobe
    input  wire logic              fb_fcs_bad,    // Check failed
    input  wire logic              fb_rx_push,    // Byte push
    input  wire logic              fb_fifo_full,  // FIFO full
    input  wire logic              fb_msg_done,   // Packet checked
    input  wire logic              fb_fifo_empty, // FIFO empty
    input  wire logic              fb_head_open,  // Head opens message
    input  wire logic              fb_head_close, // Head ends message
    input  wire logic              fb_head_good,  // Head message good
    // Transmit events
    input  wire logic              tx_fifo_half_level, // Half full pulse
    input  wire logic              tx_fifo_has_room,   // Not full pulse
    input  wire logic              tx_message_done,    // Message end pulse
    // Interrupt
    output logic                   irq            // Level, active high
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        hrs_phase_t        phase;
        logic        [7:0] wr_idx;
        logic [DATA_W-1:0] rdata;
        logic              ready;
        logic              irq;
        logic        [2:0] link_irq_mask;
        logic        [7:0] irq_mask_a;
        logic        [7:0] irq_mask_b;
        logic        [2:0] tx_events;
    } hrs_top_state_t;

    hrs_top_state_t st_ff;
    hrs_top_state_t nxt_st;

    logic [7:0] stat_a;
    logic [7:0] stat_b;
    logic       addr_ok;
    logic [7:0] idx;
    logic       rd_req;
    logic       rd_clr_a;
    logic       rd_clr_b;
    logic       rd_clr_tx;
    logic [2:0] tx_set;

    // ---------------------------------------------------------------
    // Address phase decode
    // ---------------------------------------------------------------
    // Only NONSEQ or SEQ with the bus ready counts; hsize is accepted
    // as given since only whole-word transfers are issued.
    assign addr_ok   = hsel && htrans[1] && hready;
    assign idx       = haddr[ADDR_W-1:2];
    assign rd_req    = addr_ok && !hwrite;
    assign rd_clr_a  = rd_req && (idx == IDX_STATUS_A);
    assign rd_clr_b  = rd_req && (idx == IDX_STATUS_B);
    assign rd_clr_tx = rd_req && (idx == IDX_TX_EVENTS);
    assign tx_set    = {tx_fifo_half_level, tx_fifo_has_room,
                        tx_message_done};

    // ---------------------------------------------------------------
    // Per-framer status
    // ---------------------------------------------------------------
    // Same logic twice; each copy clears only on a read of its own
    // address so one framer's events survive the other's poll.
    hrs_framer_status u_fa (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .rx_bit            (fa_rx_bit),
        .rx_bit_en         (fa_rx_bit_en),
        .fcs_bad           (fa_fcs_bad),
        .rx_push           (fa_rx_push),
        .rx_fifo_full      (fa_fifo_full),
        .msg_checked       (fa_msg_done),
        .rx_fifo_empty_now (fa_fifo_empty),
        .head_open         (fa_head_open),
        .head_close        (fa_head_close),
        .head_good         (fa_head_good),
        .rd_clr            (rd_clr_a),
        .rx_link_status    (stat_a)
    );

    hrs_framer_status u_fb (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .rx_bit            (fb_rx_bit),
        .rx_bit_en         (fb_rx_bit_en),
        .fcs_bad           (fb_fcs_bad),
        .rx_push           (fb_rx_push),
        .rx_fifo_full      (fb_fifo_full),
        .msg_checked       (fb_msg_done),
        .rx_fifo_empty_now (fb_fifo_empty),
        .head_open         (fb_head_open),
        .head_close        (fb_head_close),
        .head_good         (fb_head_good),
        .rd_clr            (rd_clr_b),
        .rx_link_status    (stat_b)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.ready = 1'b1;

        // Read data is captured at the address phase edge, so the
        // data phase needs no wait state and hrdata is a flop.
        nxt_st.rdata = '0;
        if (rd_req) begin
            case (idx)
                IDX_STATUS_A:   nxt_st.rdata[7:0] = stat_a;
                IDX_STATUS_B:   nxt_st.rdata[7:0] = stat_b;
                IDX_LINK_MASK:  nxt_st.rdata[2:0] = st_ff.link_irq_mask;
                IDX_IRQ_MASK_A: nxt_st.rdata[7:0] = st_ff.irq_mask_a;
                IDX_IRQ_MASK_B: nxt_st.rdata[7:0] = st_ff.irq_mask_b;
                IDX_TX_EVENTS:  nxt_st.rdata[2:0] = st_ff.tx_events;
                default:        nxt_st.rdata      = '0;
            endcase
        end

        // Writes land at the end of the data phase
        case (st_ff.phase)
            HRS_PH_WRITE: begin
                case (st_ff.wr_idx)
                    IDX_LINK_MASK: begin
                        nxt_st.link_irq_mask = hwdata[2:0];
                    end
                    IDX_IRQ_MASK_A: begin
                        nxt_st.irq_mask_a = hwdata[7:0];
                    end
                    IDX_IRQ_MASK_B: begin
                        nxt_st.irq_mask_b = hwdata[7:0];
                    end
                    default: begin
                        // Status and transmit event bytes are read-only; others unmapped
                        nxt_st.wr_idx = st_ff.wr_idx;
                    end
                endcase
            end
            HRS_PH_IDLE: begin
                nxt_st.wr_idx = st_ff.wr_idx;
            end
            default: begin
                nxt_st.wr_idx = st_ff.wr_idx;
            end
        endcase

        // A new address phase may overlap the data phase above
        if (addr_ok && hwrite) begin
            nxt_st.phase  = HRS_PH_WRITE;
            nxt_st.wr_idx = idx;
        end else begin
            nxt_st.phase = HRS_PH_IDLE;
        end

        // Transmit events are sticky; a set beats the read clear
        nxt_st.tx_events = (st_ff.tx_events & {3{!rd_clr_tx}}) | tx_set;

        // One level interrupt; a mask bit of one lets its event through
        nxt_st.irq = |(stat_a & st_ff.irq_mask_a)
                   | |(stat_b & st_ff.irq_mask_b)
                   | |(st_ff.tx_events & st_ff.link_irq_mask);
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{phase:         HRS_PH_IDLE,
                       wr_idx:        8'h00,
                       rdata:         32'h0000_0000,
                       ready:         1'b1,
                       irq:           1'b0,
                       link_irq_mask: LINK_MASK_RST,
                       irq_mask_a:    IRQ_MASK_RST,
                       irq_mask_b:    IRQ_MASK_RST,
                       tx_events:     TX_EVENTS_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // hresp is a constant OKAY; it needs no state of its own
    assign hrdata    = st_ff.rdata;
    assign hreadyout = st_ff.ready;
    assign hresp     = 1'b0;
    assign irq       = st_ff.irq;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_read_a;
        rd_clr_a && !fa_msg_done;
    endsequence

    sequence s_read_b;
        rd_req && idx == IDX_STATUS_B;
    endsequence

    sequence s_mask_write;
        st_ff.phase == HRS_PH_WRITE && st_ff.wr_idx == IDX_LINK_MASK;
    endsequence

    a_status_b_read: assert property (
        s_read_b |=> hrdata == {24'h00_0000, $past(stat_b)})
        else $error("framer b status not returned");

    a_status_a_addr: assert property (
        rd_req && haddr == {IDX_STATUS_A, 2'b00}
        |=> hrdata[7:0] == $past(stat_a) && hrdata[31:8] == 24'h00_0000)
        else $error("framer a status not returned");

    a_msg_cleared: assert property (
        s_read_a |=> !stat_a[BIT_MSG])
        else $error("message flag not cleared by read");

    a_mask_write: assert property (
        s_mask_write |=> st_ff.link_irq_mask == $past(hwdata[2:0]))
        else $error("transmit mask write lost");

    a_tx_irq_gate: assert property (
        st_ff.tx_events != 3'h0 && st_ff.link_irq_mask == 3'h0
        && (stat_a & st_ff.irq_mask_a) == 8'h00
        && (stat_b & st_ff.irq_mask_b) == 8'h00
        |=> !irq)
        else $error("masked transmit event raised interrupt");

    a_tx_irq_pass: assert property (
        st_ff.tx_events[BIT_TX_HALF] && st_ff.link_irq_mask[BIT_TX_HALF]
        |=> irq)
        else $error("enabled transmit event gave no interrupt");

    a_ready_const: assert property (
        hreadyout && !hresp)
        else $error("slave stalled or erred");

endmodule : hrs_status_top

// >>> hrs_far_model.sv
// Far-side model of one framer's receive bit stream and FIFO head
module hrs_far_model
    import hrs_pkg::*;
(
    input  wire logic hclk,       // Device clock
    output logic      rx_bit,     // Data-link bit
    output logic      rx_bit_en,  // Bit strobe
    output logic      fcs_bad,    // Check failed pulse
    output logic      rx_push,    // Byte push pulse
    output logic      fifo_full,  // FIFO full level
    output logic      msg_done,   // Packet checked pulse
    output logic      fifo_empty, // FIFO empty level
    output logic      head_open,  // Head opens message
    output logic      head_close, // Head ends message
    output logic      head_good   // Head message good
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet line at time zero: empty FIFO, no strobes
    initial begin
        {rx_bit, rx_bit_en, fcs_bad, rx_push, msg_done} = 5'h00;
        {fifo_full, fifo_empty, head_open, head_close, head_good} = 5'h08;
    end

    // Bits go out first bit first; the idle line shows the inverse level
    task automatic send_bits(input logic [7:0] pat, input int n);
        for (int i = 0; i < n; i++) begin
            rx_bit    <= pat[i];
            rx_bit_en <= 1'b1;
            @(posedge hclk);
        end
        rx_bit    <= ~pat[n-1];
        rx_bit_en <= 1'b0;
    endtask : send_bits

    // One-cycle event pulse: 0 check failed, 1 push, 2 packet checked
    task automatic pulse(input int k);
        fcs_bad  <= (k == 0);
        rx_push  <= (k == 1);
        msg_done <= (k == 2);
        @(posedge hclk);
        {fcs_bad, rx_push, msg_done} <= 3'h0;
    endtask : pulse

    // Levels: full, empty, open, close, good
    task automatic set_lv(input logic [4:0] v);
        {fifo_full, fifo_empty, head_open, head_close, head_good} <= v;
    endtask : set_lv
endmodule : hrs_far_model

// >>> hrs_status_top_tb_top.sv
// Self-checking bench for the two-framer receive status block
module hrs_status_top_tb_top
    import hrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              hclk = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel = 1'b0;
    logic [ADDR_W-1:0] haddr = '0;
    logic        [1:0] htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic        [2:0] hsize = 3'h2;
    logic [DATA_W-1:0] hwdata = '0;
    logic [DATA_W-1:0] hrdata;
    logic              hreadyout, hresp, irq;
    logic        [2:0] tx_ev = 3'h0;
    wire               hready = hreadyout;
    wire fa_rx_bit, fa_rx_bit_en, fa_fcs_bad, fa_rx_push, fa_fifo_full;
    wire fa_msg_done, fa_fifo_empty, fa_head_open, fa_head_close, fa_head_good;
    wire fb_rx_bit, fb_rx_bit_en, fb_fcs_bad, fb_rx_push, fb_fifo_full;
    wire fb_msg_done, fb_fifo_empty, fb_head_open, fb_head_close, fb_head_good;
    int          bad_count = 0;
    int          cmp_count = 0;
    logic [31:0] seed = 32'had5b;
    logic  [7:0] st[2];   // Expected sticky flags per framer
    logic  [4:0] lvl[2];  // Levels handed to each partner
    logic [31:0] rd;
    logic  [7:0] evx[6] = '{8'h40, 8'h00, 8'h10, 8'h00, 8'h80, 8'h20};

    hrs_status_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .fa_rx_bit, .fa_rx_bit_en, .fa_fcs_bad, .fa_rx_push, .fa_fifo_full,
        .fa_msg_done, .fa_fifo_empty, .fa_head_open, .fa_head_close,
        .fa_head_good, .fb_rx_bit, .fb_rx_bit_en, .fb_fcs_bad, .fb_rx_push,
        .fb_fifo_full, .fb_msg_done, .fb_fifo_empty, .fb_head_open,
        .fb_head_close, .fb_head_good, .tx_fifo_half_level(tx_ev[2]),
        .tx_fifo_has_room(tx_ev[1]), .tx_message_done(tx_ev[0]), .irq);
    hrs_far_model far_a (.hclk, .rx_bit(fa_rx_bit), .rx_bit_en(fa_rx_bit_en),
        .fcs_bad(fa_fcs_bad), .rx_push(fa_rx_push), .fifo_full(fa_fifo_full),
        .msg_done(fa_msg_done), .fifo_empty(fa_fifo_empty),
        .head_open(fa_head_open), .head_close(fa_head_close),
        .head_good(fa_head_good));
    hrs_far_model far_b (.hclk, .rx_bit(fb_rx_bit), .rx_bit_en(fb_rx_bit_en),
        .fcs_bad(fb_fcs_bad), .rx_push(fb_rx_push), .fifo_full(fb_fifo_full),
        .msg_done(fb_msg_done), .fifo_empty(fb_fifo_empty),
        .head_open(fb_head_open), .head_close(fb_head_close),
        .head_good(fb_head_good));

    // 25 MHz device clock
    always #20 hclk = ~hclk;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [9:0] ba(input logic [7:0] i);
        return {i, 2'b00};
    endfunction : ba

    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk

    // Single AHB-Lite transfer; the wait is unbounded, a hang is left to the watchdog
    task automatic ahb(input logic [9:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    // Read a status byte against the model; the read clears sticky flags
    task automatic chk_st(input int f);
        logic [31:0] e;
        e = {24'h0, st[f][7:4], lvl[f][3], lvl[f][1] & lvl[f][0],
             lvl[f][1], lvl[f][2]};
        ahb(ba(f ? IDX_STATUS_B : IDX_STATUS_A), 1'b0, 32'h0, rd);
        st[f] = 8'h00;
        chk("status", e, rd);
    endtask : chk_st

    task automatic lv(input int f, input logic [4:0] v);
        lvl[f] = v;
        if (f == 0) far_a.set_lv(v);
        else far_b.set_lv(v);
    endtask : lv

    // Events 0..2 are pulses; 3 sends six ones, 4 seven ones, then a zero
    task automatic ev(input int f, input int k);
        if (f == 0 && k < 3) far_a.pulse(k);
        else if (f == 0) far_a.send_bits(k == 3 ? 8'h3f : 8'h7f, k + 4);
        else if (k < 3) far_b.pulse(k);
        else far_b.send_bits(k == 3 ? 8'h3f : 8'h7f, k + 4);
    endtask : ev

    task automatic tx_pulse(input logic [2:0] m);
        tx_ev <= m;
        @(posedge hclk);
        tx_ev <= 3'h0;
    endtask : tx_pulse

    // Watchdog: the run needs a few hundred cycles at most
    initial begin
        #(40 * 20000);
        bad_count++;
        end_sim();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        st  = '{8'h00, 8'h00};
        lvl = '{5'h08, 5'h08};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("resp_rdy", 32'h1, {30'h0, hresp, hreadyout});
        chk_st(0);
        chk_st(1);
        ahb(ba(IDX_IRQ_MASK_A), 1'b0, 32'h0, rd);
        chk("mask_a", {24'h0, IRQ_MASK_RST}, rd);
        ahb(ba(IDX_LINK_MASK), 1'b0, 32'h0, rd);
        chk("link_mask", {29'h0, LINK_MASK_RST}, rd);
        // Head tags and empty bit follow random levels
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            lv(i % 2, {1'b0, seed[3:0]});
            repeat (3) @(posedge hclk);
            chk_st(i % 2);
        end
        // Each sticky event, set once and cleared by one read
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 6; k++) begin
                lv(f, (k == 5) ? 5'h18 : 5'h08);
                @(posedge hclk);
                ev(f, (k == 5) ? 1 : k);
                st[f] = evx[k];
                repeat (3) @(posedge hclk);
                chk("irq", 32'h0, {31'h0, irq});
                chk_st(f);
                chk_st(f);
            end
            lv(f, 5'h08);
            // Unmasked error raises the line until the read clears it
            ahb(ba(f ? IDX_IRQ_MASK_B : IDX_IRQ_MASK_A), 1'b1, 32'h40, rd);
            ev(f, 0);
            st[f] = 8'h40;
            repeat (4) @(posedge hclk);
            chk("irq", 32'h1, {31'h0, irq});
            chk_st(f);
            repeat (3) @(posedge hclk);
            chk("irq", 32'h0, {31'h0, irq});
            ahb(ba(f ? IDX_IRQ_MASK_B : IDX_IRQ_MASK_A), 1'b1, 32'h0, rd);
        end
        // Writes to a status byte and reads of a hole change nothing
        ahb(10'h3fc, 1'b0, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        ahb(ba(IDX_STATUS_A), 1'b1, 32'hff, rd);
        chk_st(0);
        // Transmit events against the link mask
        tx_pulse(3'h7);
        repeat (3) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        ahb(ba(IDX_TX_EVENTS), 1'b0, 32'h0, rd);
        chk("tx_events", 32'h7, rd);
        ahb(ba(IDX_LINK_MASK), 1'b1, 32'h4, rd);
        ahb(ba(IDX_LINK_MASK), 1'b0, 32'h0, rd);
        chk("link_mask", 32'h4, rd);
        tx_pulse(3'h2);
        repeat (3) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        tx_pulse(3'h4);
        repeat (3) @(posedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        ahb(ba(IDX_TX_EVENTS), 1'b0, 32'h0, rd);
        chk("tx_events", 32'h6, rd);
        repeat (3) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        end_sim();
    end
endmodule : hrs_status_top_tb_top
